// File: design/peq_qualifier.sv
// Purpose: Qualifies pipeline, bus, FPU and breakpoint events into a
//          per-clock increment for the selected performance counter.
// Assumes: All inputs except rst_n synchronous to mclk; one bus cycle start pulse per
//          physical bus cycle, with a restart flag after a backoff.
// Notes:   The counter itself lives outside this block.
//
// Behaviour
// R1: Event 1AH adds one each clock the pipe waits on data read.
// R2: Read stall also counts data TLB miss and unbypassed reads during fill.
// R3: Event 1BH counts each stall on write to E or M line.
// R4: Locked event counts read part of locked sequence only, not write.
// R5: Split locked cycle counts as two separate accesses.
// R6: Bus cycles restarted after backoff are not counted again.
// R7: Event 1DH counts each bus cycle to I/O space.
// R8: Misaligned I/O access gives two bus cycles, so counts two.
// R9: Event 1EH counts noncacheable memory reads incl TLB, not I/O.
// R10: Event 1FH counts address interlock stalls in either pipe.
// R11: Interlocks in both pipes in one clock add two.
// R12: Interlock when execute stage writes base/index of generation stage.
// R13: Event 22H counts float add, sub, mul, div, remainder, sqrt.
// R14: Each internal add or multiply of transcendentals is counted.
// R15: Divide-by-zero, negative sqrt, special operand, stack faults excluded.
// R16: Integer multiplies and other FPU users are counted too.
// R17: Events 23H/24H count breakpoint 0/1 matches, enabled or not.
// R18: With breakpoints disabled, second-pipe code matches never count.
// R19: Breakpoint counts follow the breakpoint match pins.
// R20: Reserved codes 20H and 21H never increment.
`timescale 1ns/1ps
`default_nettype none
`include "peq_consts.svh"

module peq_qualifier
    import peq_pkg::*;
(
    input  wire logic       mclk,            // Core clock, 100 MHz.
    input  wire logic       rst_n,           // Async reset, active low.
    input  wire peq_event_t event_sel,       // Selected event code.
    input  wire logic       read_wait,       // Pipe waits on data read.
    input  wire logic       dtlb_miss_busy,  // Data TLB miss handling.
    input  wire logic       fill_read_block, // Read not bypassed in fill.
    input  wire logic       write_em_stall,  // Stall start, write to E/M.
    input  wire logic       bus_start,       // Bus cycle start pulse.
    input  wire logic       bus_restart,     // Start is a backoff restart.
    input  wire logic       bus_locked,      // Cycle carries lock.
    input  wire logic       bus_write,       // Cycle is a write.
    input  wire logic       bus_io,          // Cycle targets I/O space.
    input  wire logic       bus_cacheable,   // Cycle is cacheable.
    input  wire logic       split_cycle_indicator, // Split locked access.
    input  wire logic       u_ex_wr,         // Pipe 1 execute writes reg.
    input  wire logic [2:0] u_ex_reg,        // Pipe 1 execute dest reg.
    input  wire logic       v_ex_wr,         // Pipe 2 execute writes reg.
    input  wire logic [2:0] v_ex_reg,        // Pipe 2 execute dest reg.
    input  wire logic       u_ag_valid,      // Pipe 1 generation busy.
    input  wire logic [2:0] u_ag_base,       // Pipe 1 base register.
    input  wire logic [2:0] u_ag_index,      // Pipe 1 index register.
    input  wire logic       v_ag_valid,      // Pipe 2 generation busy.
    input  wire logic [2:0] v_ag_base,       // Pipe 2 base register.
    input  wire logic [2:0] v_ag_index,      // Pipe 2 index register.
    input  wire logic       fpu_op,          // Arith op or internal step.
    input  wire logic       fpu_excluded_exc, // Op raised excluded fault.
    input  wire logic       bkpt_enabled,    // Any breakpoint enabled.
    input  wire logic [3:0] bp_match_u,      // Pipe 1 matches per register.
    input  wire logic [3:0] bp_match_v,      // Pipe 2 code matches.
    output var  peq_inc_t   count_inc,       // Increment for the counter.
    output logic [3:0]      breakpoint_match_pins // Match indication pins.
);

    // ------------------------------------------------------------
    // Lock sequence tracking
    // ------------------------------------------------------------
    peq_lock_e lk_q;
    peq_lock_e lk_d;

    always_comb begin
        lk_d = lk_q;
        if (bus_start && !bus_restart) begin
            if (!bus_locked)
                lk_d = PEQ_LK_IDLE;
            else if (bus_write)
                lk_d = PEQ_LK_WRITE;
            else
                lk_d = PEQ_LK_READ;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n)
            lk_q <= PEQ_LK_IDLE;
        else
            lk_q <= lk_d;
    end

    // ------------------------------------------------------------
    // Event qualification
    // ------------------------------------------------------------
    logic       new_cycle;
    logic       u_agi;
    logic       v_agi;
    logic [3:0] bp_hits;
    peq_inc_t   inc_d;
    peq_inc_t   inc_q;
    logic [3:0] bp_d;
    logic [3:0] bp_q;

    // A restart repeats a cycle already seen, so it never counts again.
    assign new_cycle = bus_start && !bus_restart; // R6

    // R12
    assign u_agi = u_ag_valid &&
        ((u_ex_wr && (u_ex_reg == u_ag_base || u_ex_reg == u_ag_index)) ||
         (v_ex_wr && (v_ex_reg == u_ag_base || v_ex_reg == u_ag_index)));
    assign v_agi = v_ag_valid &&
        ((u_ex_wr && (u_ex_reg == v_ag_base || u_ex_reg == v_ag_index)) ||
         (v_ex_wr && (v_ex_reg == v_ag_base || v_ex_reg == v_ag_index)));

    // Pipe 2 code matches are only looked at once breakpoints are on.
    assign bp_hits = bp_match_u | (bkpt_enabled ? bp_match_v : `PEQ_BP_NONE); // R18

    always_comb begin
        inc_d = `PEQ_INC_ZERO;
        bp_d  = bp_hits; // R19
        case (event_sel)
            `PEQ_EV_READ_STALL: begin
                if (read_wait || dtlb_miss_busy || fill_read_block) // R1 R2
                    inc_d = `PEQ_INC_ONE;
            end
            `PEQ_EV_WRITE_EM: begin
                if (write_em_stall) // R3
                    inc_d = `PEQ_INC_ONE;
            end
            `PEQ_EV_LOCKED: begin
                // Split halves arrive as separate starts and each counts.
                if (new_cycle && bus_locked && !bus_write) // R4 R5
                    inc_d = `PEQ_INC_ONE;
            end
            `PEQ_EV_IO_CYCLE: begin
                if (new_cycle && bus_io) // R7 R8
                    inc_d = `PEQ_INC_ONE;
            end
            `PEQ_EV_NC_READ: begin
                if (new_cycle && !bus_io && !bus_write && !bus_cacheable) // R9
                    inc_d = `PEQ_INC_ONE;
            end
            `PEQ_EV_INTERLOCK: begin
                inc_d = {1'b0, u_agi} + {1'b0, v_agi}; // R10 R11
            end
            `PEQ_EV_FLOAT: begin
                if (fpu_op && !fpu_excluded_exc) // R13 R14 R15 R16
                    inc_d = `PEQ_INC_ONE;
            end
            `PEQ_EV_BKPT0: begin
                if (bp_hits[`PEQ_BP_ZERO]) // R17
                    inc_d = `PEQ_INC_ONE;
            end
            `PEQ_EV_BKPT1: begin
                if (bp_hits[`PEQ_BP_ONE]) // R17
                    inc_d = `PEQ_INC_ONE;
            end
            default: begin
                inc_d = `PEQ_INC_ZERO; // R20
            end
        endcase
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            inc_q <= `PEQ_INC_ZERO;
            bp_q  <= `PEQ_BP_NONE;
        end else begin
            inc_q <= inc_d;
            bp_q  <= bp_d;
        end
    end

    assign count_inc             = inc_q;
    assign breakpoint_match_pins = bp_q;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    property p_read_stall;
        @(posedge mclk) disable iff (!rst_n)
        (event_sel == `PEQ_EV_READ_STALL && (read_wait || dtlb_miss_busy))
        |=> count_inc == `PEQ_INC_ONE;
    endproperty
    a_read_stall: assert property (p_read_stall) // R1
        else $error("read stall clock not counted");

    property p_read_fill;
        @(posedge mclk) disable iff (!rst_n)
        (event_sel == `PEQ_EV_READ_STALL && fill_read_block)
        |=> count_inc == `PEQ_INC_ONE;
    endproperty
    a_read_fill: assert property (p_read_fill) // R2
        else $error("unbypassed read during fill not counted");

    property p_write_em;
        @(posedge mclk) disable iff (!rst_n)
        (event_sel == `PEQ_EV_WRITE_EM) |=> count_inc == $past(write_em_stall);
    endproperty
    a_write_em: assert property (p_write_em) // R3
        else $error("write stall count mismatch");

    property p_lock_write;
        @(posedge mclk) disable iff (!rst_n)
        (event_sel == `PEQ_EV_LOCKED && bus_write) |=> count_inc == 2'h0;
    endproperty
    a_lock_write: assert property (p_lock_write) // R4
        else $error("locked write part counted");

    property p_split;
        @(posedge mclk) disable iff (!rst_n)
        (event_sel == `PEQ_EV_LOCKED && new_cycle && bus_locked &&
            !bus_write && split_cycle_indicator)
        |=> count_inc == `PEQ_INC_ONE;
    endproperty
    a_split: assert property (p_split) // R5
        else $error("split locked half not counted");

    property p_restart;
        @(posedge mclk) disable iff (!rst_n)
        (bus_restart && event_sel inside {`PEQ_EV_LOCKED, `PEQ_EV_IO_CYCLE,
            `PEQ_EV_NC_READ}) |=> count_inc == 2'h0;
    endproperty
    a_restart: assert property (p_restart) // R6
        else $error("restarted cycle counted");

    property p_io;
        @(posedge mclk) disable iff (!rst_n)
        (event_sel == `PEQ_EV_IO_CYCLE && bus_start && !bus_restart && bus_io)
        |=> count_inc == 2'h1;
    endproperty
    a_io: assert property (p_io) // R7
        else $error("io cycle not counted");

    property p_nc_io;
        @(posedge mclk) disable iff (!rst_n)
        (event_sel == `PEQ_EV_NC_READ && bus_io) |=> count_inc == 2'h0;
    endproperty
    a_nc_io: assert property (p_nc_io) // R9
        else $error("io read counted as noncacheable");

    property p_agi_two;
        @(posedge mclk) disable iff (!rst_n)
        (event_sel == `PEQ_EV_INTERLOCK && u_agi && v_agi)
        |=> count_inc == 2'h2;
    endproperty
    a_agi_two: assert property (p_agi_two) // R11
        else $error("dual interlock not counted as two");

    property p_agi_base;
        @(posedge mclk) disable iff (!rst_n)
        (event_sel == `PEQ_EV_INTERLOCK && u_ag_valid && u_ex_wr &&
            u_ex_reg == u_ag_base)
        |=> count_inc != `PEQ_INC_ZERO;
    endproperty
    a_agi_base: assert property (p_agi_base) // R12
        else $error("base register interlock not counted");

    property p_float;
        @(posedge mclk) disable iff (!rst_n)
        (event_sel == `PEQ_EV_FLOAT && fpu_op && !fpu_excluded_exc)
        |=> count_inc == `PEQ_INC_ONE;
    endproperty
    a_float: assert property (p_float) // R13
        else $error("float operation not counted");

    property p_fpu_exc;
        @(posedge mclk) disable iff (!rst_n)
        (event_sel == `PEQ_EV_FLOAT && fpu_excluded_exc) |=> count_inc == 2'h0;
    endproperty
    a_fpu_exc: assert property (p_fpu_exc) // R15
        else $error("excluded float fault counted");

    property p_bp_v;
        @(posedge mclk) disable iff (!rst_n)
        (!bkpt_enabled && bp_match_u == 4'h0)
        |=> breakpoint_match_pins == 4'h0;
    endproperty
    a_bp_v: assert property (p_bp_v) // R18
        else $error("pipe 2 match seen while disabled");

    property p_bkpt0;
        @(posedge mclk) disable iff (!rst_n)
        (event_sel == `PEQ_EV_BKPT0 && bp_match_u[`PEQ_BP_ZERO])
        |=> count_inc == `PEQ_INC_ONE;
    endproperty
    a_bkpt0: assert property (p_bkpt0) // R17
        else $error("pipe 1 match on register zero not counted");

    property p_bp_pin;
        @(posedge mclk) disable iff (!rst_n)
        (event_sel == `PEQ_EV_BKPT1)
        |=> count_inc == {1'b0, breakpoint_match_pins[1]};
    endproperty
    a_bp_pin: assert property (p_bp_pin) // R19
        else $error("breakpoint count differs from pins");

    property p_rsvd;
        @(posedge mclk) disable iff (!rst_n)
        (event_sel == `PEQ_EV_RSVD0 || event_sel == `PEQ_EV_RSVD1)
        |=> count_inc == 2'h0;
    endproperty
    a_rsvd: assert property (p_rsvd) // R20
        else $error("reserved code incremented");

    c_agi_two: cover property (@(posedge mclk) disable iff (!rst_n)
        event_sel == `PEQ_EV_INTERLOCK && u_agi && v_agi);
    c_split: cover property (@(posedge mclk) disable iff (!rst_n)
        event_sel == `PEQ_EV_LOCKED && split_cycle_indicator && new_cycle);
    c_restart: cover property (@(posedge mclk) disable iff (!rst_n)
        bus_start && bus_restart && bus_io);
    c_lock_rmw: cover property (@(posedge mclk) disable iff (!rst_n)
        lk_q == PEQ_LK_READ && new_cycle && bus_locked && bus_write);

endmodule

`default_nettype wire

// File: shared/peq_consts.svh
// Purpose: Constants for the performance event qualifier.
// Assumes: Six-bit event select codes.
// Notes:   Offsets and codes only; no logic.
`ifndef PEQ_CONSTS_SVH
`define PEQ_CONSTS_SVH
`define PEQ_EV_READ_STALL   6'h1a
`define PEQ_EV_WRITE_EM     6'h1b
`define PEQ_EV_LOCKED       6'h1c
`define PEQ_EV_IO_CYCLE     6'h1d
`define PEQ_EV_NC_READ      6'h1e
`define PEQ_EV_INTERLOCK    6'h1f
`define PEQ_EV_RSVD0        6'h20
`define PEQ_EV_RSVD1        6'h21
`define PEQ_EV_FLOAT        6'h22
`define PEQ_EV_BKPT0        6'h23
`define PEQ_EV_BKPT1        6'h24
`define PEQ_INC_ZERO        2'h0
`define PEQ_INC_ONE         2'h1
`define PEQ_INC_TWO         2'h2
`define PEQ_BP_ZERO         0
`define PEQ_BP_ONE          1
`define PEQ_BP_NONE         4'h0
`endif

// File: shared/peq_pkg.sv
// Purpose: Types for the performance event qualifier.
// Assumes: Constants come from peq_consts.svh.
// Notes:   Increment is 0, 1 or 2 per clock.
package peq_pkg;
    typedef logic [5:0] peq_event_t;
    typedef logic [1:0] peq_inc_t;
    typedef enum logic [1:0] {
        PEQ_LK_IDLE,
        PEQ_LK_READ,
        PEQ_LK_WRITE
    } peq_lock_e;
endpackage

// File: test/peq_source.sv
// Purpose: Far-side sources: pipe stalls, bus unit, FPU, comparators.
// Assumes: Tasks are called just after a rising edge of mclk.
// Notes:   Strobes stay up until idle is called.
`timescale 1ns/1ps
`default_nettype none
module peq_source (
    output logic       read_wait,             // Read stall.
    output logic       dtlb_miss_busy,        // TLB miss.
    output logic       fill_read_block,       // Fill block.
    output logic       write_em_stall,        // E/M stall.
    output logic       bus_start,             // Cycle start.
    output logic       bus_restart,           // Backoff restart.
    output logic       bus_locked,            // Locked.
    output logic       bus_write,             // Write.
    output logic       bus_io,                // I/O space.
    output logic       bus_cacheable,         // Cacheable.
    output logic       split_cycle_indicator, // Split.
    output logic       u_ex_wr,               // Pipe 1 writes.
    output logic [2:0] u_ex_reg,              // Pipe 1 dest.
    output logic       v_ex_wr,               // Pipe 2 writes.
    output logic [2:0] v_ex_reg,              // Pipe 2 dest.
    output logic       u_ag_valid,            // Pipe 1 gen.
    output logic [2:0] u_ag_base,             // Pipe 1 base.
    output logic [2:0] u_ag_index,            // Pipe 1 index.
    output logic       v_ag_valid,            // Pipe 2 gen.
    output logic [2:0] v_ag_base,             // Pipe 2 base.
    output logic [2:0] v_ag_index,            // Pipe 2 index.
    output logic       fpu_op,                // FPU op.
    output logic       fpu_excluded_exc,      // Excluded fault.
    output logic       bkpt_enabled,          // Bkpt enable.
    output logic [3:0] bp_match_u,            // Pipe 1 match.
    output logic [3:0] bp_match_v             // Pipe 2 match.
);
    task automatic idle();
        {read_wait, dtlb_miss_busy, fill_read_block, write_em_stall} = 4'h0;
        {bus_start, bus_restart, u_ex_wr, v_ex_wr} = 4'h0;
        {u_ag_valid, v_ag_valid, fpu_op, fpu_excluded_exc} = 4'h0;
        bp_match_u = 4'h0;
        bp_match_v = 4'h0;
        // Released attributes flip so a stale value never looks valid.
        {bus_locked, bus_write, bus_io, bus_cacheable} =
            ~{bus_locked, bus_write, bus_io, bus_cacheable};
        split_cycle_indicator = ~split_cycle_indicator;
    endtask
    task automatic stall(input logic rw, tl, fl, em);
        {read_wait, dtlb_miss_busy, fill_read_block, write_em_stall} =
            {rw, tl, fl, em};
    endtask
    task automatic bus(input logic lk, wr, io, ca, rs, sc);
        bus_start = 1'b1;
        {bus_locked, bus_write, bus_io, bus_cacheable} = {lk, wr, io, ca};
        {bus_restart, split_cycle_indicator} = {rs, sc};
    endtask
    task automatic address_interlock(input logic [3:0] ue, ve, input logic [6:0] ua, va);
        {u_ex_wr, u_ex_reg, v_ex_wr, v_ex_reg} = {ue, ve};
        {u_ag_valid, u_ag_base, u_ag_index} = ua;
        {v_ag_valid, v_ag_base, v_ag_index} = va;
    endtask
    task automatic fpu(input logic op, ex);
        {fpu_op, fpu_excluded_exc} = {op, ex};
    endtask
    task automatic bp(input logic en, input logic [3:0] mu, mv);
        {bkpt_enabled, bp_match_u, bp_match_v} = {en, mu, mv};
    endtask
    initial begin
        {bus_locked, bus_write, bus_io, bus_cacheable} = 4'h0;
        split_cycle_indicator = 1'b0;
        {u_ex_reg, v_ex_reg, u_ag_base, u_ag_index} = 12'h0;
        {v_ag_base, v_ag_index} = 6'h0;
        bkpt_enabled = 1'b0;
        idle();
    end
endmodule
`default_nettype wire

// File: test/peq_qualifier_bench.sv
// Purpose: Self-checking bench for the event qualifier.
// Assumes: Outputs register on the sampling edge, one edge after the inputs change.
// Notes:   Inputs change 1 ns after each rising edge.
`timescale 1ns/1ps
`default_nettype none
`include "peq_consts.svh"
module peq_qualifier_bench import peq_pkg::*;;
    logic       mclk = 1'b0;
    logic       rst_n;
    peq_event_t event_sel;
    peq_inc_t   count_inc;
    logic [3:0] breakpoint_match_pins;
    logic read_wait, dtlb_miss_busy, fill_read_block, write_em_stall;
    logic bus_start, bus_restart, bus_locked, bus_write, bus_io;
    logic bus_cacheable, split_cycle_indicator, fpu_op, fpu_excluded_exc;
    logic u_ex_wr, v_ex_wr, u_ag_valid, v_ag_valid, bkpt_enabled;
    logic [2:0] u_ex_reg, v_ex_reg, u_ag_base, u_ag_index, v_ag_base;
    logic [2:0] v_ag_index;
    logic [3:0] bp_match_u, bp_match_v;
    int mismatches = 0;
    int total_checks = 0;
    peq_qualifier dut_u (.*);
    peq_source src_u (.*);
    always #5 mclk = ~mclk;
    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    task automatic chk(input string what, input logic [3:0] seen, exp);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic step(input logic [3:0] exp);
        @(posedge mclk);
        #1;
        chk("count_inc", {2'h0, count_inc}, exp);
    endtask
    task automatic ev(input peq_event_t e);
        event_sel = e;
        src_u.idle();
        step(4'h0);
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_stall();
        ev(`PEQ_EV_READ_STALL);
        src_u.stall(1, 0, 0, 0);
        step(4'h1);
        src_u.stall(0, 1, 0, 0);
        step(4'h1);
        src_u.stall(0, 0, 1, 0);
        step(4'h1);
        src_u.stall(1, 1, 1, 1);
        step(4'h1);
        ev(`PEQ_EV_WRITE_EM);
        src_u.stall(0, 0, 0, 1);
        step(4'h1);
        src_u.stall(1, 1, 1, 0);
        step(4'h0);
    endtask
    task automatic t_bus();
        ev(`PEQ_EV_LOCKED);
        src_u.bus(1, 0, 0, 0, 0, 0);
        step(4'h1);
        src_u.bus(1, 1, 0, 0, 0, 0);
        step(4'h0);
        src_u.bus(1, 0, 0, 0, 0, 1);
        step(4'h1);
        src_u.bus(1, 0, 0, 0, 0, 1);
        step(4'h1);
        src_u.bus(1, 0, 0, 0, 1, 0);
        step(4'h0);
        ev(`PEQ_EV_IO_CYCLE);
        src_u.bus(0, 0, 1, 0, 0, 0);
        step(4'h1);
        src_u.bus(0, 1, 1, 0, 0, 0);
        step(4'h1);
        src_u.bus(0, 1, 1, 0, 0, 0);
        step(4'h1);
        src_u.bus(0, 0, 1, 0, 1, 0);
        step(4'h0);
        src_u.bus(0, 0, 0, 0, 0, 0);
        step(4'h0);
        ev(`PEQ_EV_NC_READ);
        src_u.bus(0, 0, 0, 0, 0, 0);
        step(4'h1);
        src_u.bus(0, 0, 1, 0, 0, 0);
        step(4'h0);
        src_u.bus(0, 0, 0, 1, 0, 0);
        step(4'h0);
        src_u.bus(0, 1, 0, 0, 0, 0);
        step(4'h0);
        src_u.bus(0, 0, 0, 0, 1, 0);
        step(4'h0);
    endtask
    task automatic t_agi();
        ev(`PEQ_EV_INTERLOCK);
        src_u.address_interlock(4'hb, 4'h0, 7'h5d, 7'h00);
        step(4'h1);
        src_u.address_interlock(4'h0, 4'he, 7'h00, 7'h56);
        step(4'h1);
        src_u.address_interlock(4'hc, 4'h0, 7'h00, 7'h61);
        step(4'h1);
        src_u.address_interlock(4'ha, 4'h0, 7'h57, 7'h7a);
        step(4'h2);
        src_u.address_interlock(4'h9, 4'h9, 7'h53, 7'h65);
        step(4'h0);
        src_u.address_interlock(4'h2, 4'h2, 7'h52, 7'h52);
        step(4'h0);
    endtask
    task automatic t_fpu();
        ev(`PEQ_EV_FLOAT);
        src_u.fpu(1, 0);
        step(4'h1);
        src_u.fpu(1, 0);
        step(4'h1);
        src_u.fpu(1, 1);
        step(4'h0);
        src_u.fpu(1, 0);
        step(4'h1);
    endtask
    task automatic t_bkpt();
        ev(`PEQ_EV_BKPT0);
        src_u.bp(0, 4'h1, 4'h0);
        step(4'h1);
        chk("pins", breakpoint_match_pins, 4'h1);
        src_u.bp(0, 4'h0, 4'h1);
        step(4'h0);
        chk("pins", breakpoint_match_pins, 4'h0);
        src_u.bp(1, 4'h0, 4'h1);
        step(4'h1);
        src_u.bp(1, 4'h2, 4'h0);
        step(4'h0);
        ev(`PEQ_EV_BKPT1);
        src_u.bp(1, 4'h2, 4'h0);
        step(4'h1);
        src_u.bp(0, 4'h0, 4'h2);
        step(4'h0);
        src_u.bp(0, 4'hc, 4'h0);
        step(4'h0);
        chk("pins", breakpoint_match_pins, 4'hc);
    endtask
    task automatic t_rsvd(input peq_event_t e);
        ev(e);
        src_u.stall(1, 1, 1, 1);
        step(4'h0);
        src_u.bus(1, 0, 1, 0, 0, 0);
        step(4'h0);
        src_u.fpu(1, 0);
        step(4'h0);
        src_u.bp(1, 4'h3, 4'h3);
        step(4'h0);
    endtask
    // ----------------------------------------------------------------
    // Main sequence and watchdog
    // ----------------------------------------------------------------
    initial begin
        rst_n = 1'b0;
        event_sel = 6'h00;
        repeat (6) @(posedge mclk);
        #1;
        chk("count_inc", {2'h0, count_inc}, 4'h0);
        rst_n = 1'b1;
        t_stall();
        t_bus();
        t_agi();
        t_fpu();
        t_bkpt();
        t_rsvd(`PEQ_EV_RSVD0);
        t_rsvd(`PEQ_EV_RSVD1);
        results();
    end
    initial begin
        // About 60 cycles of tests; a wide margin still ends a hang fast.
        repeat (2000) @(posedge mclk);
        mismatches++;
        results();
    end
endmodule
`default_nettype wire
